/* File: logic/nvc_map.vh */
// register offsets, field positions, reset values and timing for nvc block
// assumes an 8-bit register index and 16-bit data words
`ifndef NVC_MAP_VH
`define NVC_MAP_VH
`define NVC_OFS_KEY 8'h31
`define NVC_OFS_READY 8'h32
`define NVC_OFS_LOC 8'h33
`define NVC_OFS_WDATA 8'h34
`define NVC_OFS_ACC_CTRL 8'h35
`define NVC_OFS_RDATA 8'h36
`define NVC_OFS_GAP1_LO 8'h37
`define NVC_OFS_GAP1_HI 8'h5f
`define NVC_OFS_INHIBIT 8'h60
`define NVC_OFS_GAP2_LO 8'h61
`define NVC_OFS_GAP2_HI 8'h8f
`define NVC_OFS_CFG1 8'h90
`define NVC_OFS_CUST_HI 8'h96
`define NVC_BIT_SHADOW 12
`define NVC_BIT_RESYNC 8
`define NVC_BIT_WRSEL 2
`define NVC_ACC_OFF 2'b00
`define NVC_ACC_SINGLE 2'b01
`define NVC_ACC_BULK 2'b10
`define NVC_ACC_MASK 16'h1107
`define NVC_BIT_INHIBIT 15
`define NVC_RST_WORD 16'h0000
`define NVC_KEY_VALUE 16'hc0de
`define NVC_NV_DEPTH 8
`define NVC_ACCESS_NS 1000
`define NVC_ACCESS_CYC ((`NVC_ACCESS_NS + 99) / 100)
`endif

/* File: logic/nvc_store.v */
// nonvolatile array model for customer space, one word per location
// assumes a single clock; write and read ports share the latency counter
`timescale 1ns/100ps
`default_nettype none
`include "nvc_map.vh"
module nvc_store #(
  parameter DEPTH = `NVC_NV_DEPTH,
  parameter LAT = `NVC_ACCESS_CYC
) (
  input wire clk_sys,
  input wire rst,
  input wire start,
  input wire wr,
  input wire [2:0] idx,
  input wire [15:0] wdata,
  output reg busy_r,
  output reg done_r,
  output reg [15:0] rdata_r,
  output wire [16*DEPTH-1:0] all_words
);
  // -----------------------------
  // storage and latency
  // -----------------------------
  reg [15:0] mem [0:DEPTH-1];
  reg [7:0] cnt_r;
  reg wr_r;
  reg [2:0] idx_r;
  reg [15:0] wdata_r;
  integer i;
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_flat
      assign all_words[16*g +: 16] = mem[g];
    end
  endgenerate
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      cnt_r <= 8'h00;
      wr_r <= 1'b0;
      idx_r <= 3'h0;
      wdata_r <= 16'h0000;
      rdata_r <= 16'h0000;
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= 16'h0000;
      end
    end else begin
      done_r <= 1'b0;
      if (!busy_r && start) begin
        busy_r <= 1'b1;
        cnt_r <= LAT[7:0];
        wr_r <= wr;
        idx_r <= idx;
        wdata_r <= wdata;
      end else if (busy_r) begin
        if (cnt_r <= 8'h01) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          // model takes the full access time before data shows
          if (wr_r) begin
            mem[idx_r] <= wdata_r;
          end else begin
            rdata_r <= mem[idx_r];
          end
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      end
    end
  end
endmodule // nvc_store
`default_nettype wire

/* File: logic/nvc_shadow.v */
// shadow copy of the first configuration word plus reload from nv
// assumes writes come from the register port on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "nvc_map.vh"
module nvc_shadow (
  input wire clk_sys,
  input wire rst,
  input wire load_nv,
  input wire [15:0] nv_word,
  input wire host_wr,
  input wire [15:0] host_word,
  output reg [15:0] shadow_r
);
  // -----------------------------
  // shadow word
  // -----------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shadow_r <= `NVC_RST_WORD;
    end else if (load_nv) begin
      // resync beats a same-cycle host write
      shadow_r <= nv_word;
    end else if (host_wr) begin
      shadow_r <= host_word;
    end
  end
endmodule // nvc_shadow
`default_nettype wire

/* File: logic/nvc_regs.v */
// register file for nonvolatile configuration access and motor inhibit
// assumes the serial slave presents a one-cycle strobe per word access
//
// How it works
// - shadow_select high runs from shadow, low from nonvolatile contents
// - while shadow_select is high, config reads return the shadow word
// - writing nv_resync 1 copies nonvolatile contents into the shadow
// - nv_write_select picks direction: 0 read, 1 write
// - nv_access_kind: 00 off, 01 single, 10 bulk; 11 never used
// - unused control bits read zero and are not stored
// - single_read_word holds the word from the latest single read
// - offsets 0x37 to 0x5F unimplemented, read zero
// - offsets 0x61 to 0x8F unimplemented, read zero
// - drive_inhibit at bit 15 of 0x60 stops motor control, no sleep
// - drive_inhibit is write-only; its register reads all zero
// - config word at 0x90 holds six fields, writable only while shadow_select is high, reset zero
// - access control register resets to all zeros
// - nv_ready_flag at bit 0 of 0x32 shows memory ready
// - single_access_location picks the nonvolatile location
// - single write stores single_write_word at that location
`timescale 1ns/100ps
`default_nettype none
`include "nvc_map.vh"
module nvc_regs #(
  parameter NV_DEPTH = `NVC_NV_DEPTH,
  parameter ACCESS_CYC = `NVC_ACCESS_CYC
) (
  input wire clk_sys,
  input wire rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata_r,
  output reg drive_inhibit_r,
  output reg shadow_active_r,
  output reg [1:0] dither_setting_r,
  output reg [1:0] tach_openloop_select_r,
  output reg [3:0] tach_divider_r,
  output reg cycle_adjust_select_r,
  output reg [2:0] winding_res_shift_r,
  output reg [3:0] winding_res_mantissa_r
);
  // -----------------------------
  // control and data registers
  // -----------------------------
  reg [15:0] key_r;
  reg [7:0] loc_r;
  reg [15:0] wword_r;
  reg shadow_select_r;
  reg nv_write_select_r;
  reg [1:0] nv_access_kind_r;
  reg [15:0] rword_r;
  reg resync_r;
  reg pend_r;
  reg bulk_pend_r;
  reg [2:0] bulk_idx_r;
  reg bulk_run_r;
  reg [15:0] rdata_nxt;
  reg [15:0] cfg_nxt;
  wire key_ok;
  wire in_cust;
  wire wr_acc;
  wire wr_cfg;
  wire st_busy;
  wire st_done;
  wire [15:0] st_rdata;
  wire [16*NV_DEPTH-1:0] nv_words;
  wire [15:0] shadow_word;
  wire [15:0] nv_cfg;
  wire st_start;
  wire st_wr;
  wire [2:0] st_idx;
  wire [15:0] st_wdata;

  assign key_ok = (key_r == `NVC_KEY_VALUE);
  assign in_cust = (loc_r >= `NVC_OFS_CFG1) && (loc_r <= `NVC_OFS_CUST_HI);
  assign wr_acc = reg_wr && (reg_addr == `NVC_OFS_ACC_CTRL);
  assign wr_cfg = reg_wr && (reg_addr == `NVC_OFS_CFG1);
  assign nv_cfg = nv_words[15:0];

  // -----------------------------
  // access sequencing
  // -----------------------------
  // bulk walks every location, writing the shadow word at each index when nv_write_select is 1
  assign st_start = (pend_r || bulk_run_r) && !st_busy && !st_done;
  assign st_wr = bulk_run_r ? nv_write_select_r : nv_write_select_r;
  assign st_idx = bulk_run_r ? bulk_idx_r : loc_r[2:0];
  assign st_wdata = bulk_run_r ? shadow_word : wword_r;

  nvc_store #(
    .DEPTH(NV_DEPTH),
    .LAT(ACCESS_CYC)
  ) u_store (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(st_start),
    .wr(st_wr),
    .idx(st_idx),
    .wdata(st_wdata),
    .busy_r(st_busy),
    .done_r(st_done),
    .rdata_r(st_rdata),
    .all_words(nv_words)
  );

  nvc_shadow u_shadow (
    .clk_sys(clk_sys),
    .rst(rst),
    .load_nv(resync_r),
    .nv_word(nv_cfg),
    .host_wr(wr_cfg && shadow_select_r),
    .host_word(reg_wdata),
    .shadow_r(shadow_word)
  );

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      key_r <= `NVC_RST_WORD;
      loc_r <= 8'h00;
      wword_r <= `NVC_RST_WORD;
      shadow_select_r <= 1'b0;
      nv_write_select_r <= 1'b0;
      nv_access_kind_r <= `NVC_ACC_OFF;
      resync_r <= 1'b0;
      pend_r <= 1'b0;
      bulk_pend_r <= 1'b0;
      bulk_idx_r <= 3'h0;
      bulk_run_r <= 1'b0;
      rword_r <= `NVC_RST_WORD;
      drive_inhibit_r <= 1'b0;
    end else begin
      resync_r <= 1'b0;
      if (reg_wr && reg_addr == `NVC_OFS_KEY) begin
        key_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == `NVC_OFS_LOC) begin
        loc_r <= reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == `NVC_OFS_WDATA) begin
        wword_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == `NVC_OFS_INHIBIT) begin
        drive_inhibit_r <= reg_wdata[`NVC_BIT_INHIBIT];
      end
      if (wr_acc) begin
        // reserved bits are dropped, not stored
        shadow_select_r <= reg_wdata[`NVC_BIT_SHADOW];
        nv_write_select_r <= reg_wdata[`NVC_BIT_WRSEL];
        // the unused code 11 is held off rather than trusted
        nv_access_kind_r <= (reg_wdata[1:0] == 2'b11) ?
          `NVC_ACC_OFF : reg_wdata[1:0];
        resync_r <= reg_wdata[`NVC_BIT_RESYNC];
        if (reg_wdata[1:0] == `NVC_ACC_SINGLE && key_ok && in_cust &&
            !st_busy && !pend_r && !bulk_run_r) begin
          pend_r <= 1'b1;
        end
        if (reg_wdata[1:0] == `NVC_ACC_BULK && key_ok &&
            !st_busy && !pend_r && !bulk_run_r) begin
          bulk_pend_r <= 1'b1;
        end
      end
      if (bulk_pend_r) begin
        bulk_pend_r <= 1'b0;
        bulk_run_r <= 1'b1;
        bulk_idx_r <= 3'h0;
      end
      if (st_start) begin
        pend_r <= 1'b0;
      end
      if (st_done && !bulk_run_r && !nv_write_select_r) begin
        rword_r <= st_rdata;
      end
      if (st_done && bulk_run_r) begin
        if (bulk_idx_r == NV_DEPTH[2:0] - 3'h1) begin
          bulk_run_r <= 1'b0;
        end else begin
          bulk_idx_r <= bulk_idx_r + 3'h1;
        end
      end
    end
  end

  // -----------------------------
  // operating config and read mux
  // -----------------------------
  always @* begin
    cfg_nxt = shadow_select_r ? shadow_word : nv_cfg;
    rdata_nxt = 16'h0000;
    case (reg_addr)
      `NVC_OFS_KEY: rdata_nxt = key_r;
      `NVC_OFS_READY: rdata_nxt = {15'h0000,
        !(st_busy || pend_r || bulk_run_r || bulk_pend_r)};
      `NVC_OFS_LOC: rdata_nxt = {8'h00, loc_r};
      `NVC_OFS_WDATA: rdata_nxt = wword_r;
      `NVC_OFS_ACC_CTRL: rdata_nxt = {3'h0, shadow_select_r, 3'h0, 1'b0,
        5'h00, nv_write_select_r, nv_access_kind_r};
      `NVC_OFS_RDATA: rdata_nxt = rword_r;
      `NVC_OFS_INHIBIT: rdata_nxt = 16'h0000;
      `NVC_OFS_CFG1: rdata_nxt = cfg_nxt;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= 16'h0000;
      shadow_active_r <= 1'b0;
      dither_setting_r <= 2'b00;
      tach_openloop_select_r <= 2'b00;
      tach_divider_r <= 4'h0;
      cycle_adjust_select_r <= 1'b0;
      winding_res_shift_r <= 3'h0;
      winding_res_mantissa_r <= 4'h0;
    end else begin
      if (reg_rd) begin
        reg_rdata_r <= rdata_nxt;
      end
      shadow_active_r <= shadow_select_r;
      dither_setting_r <= cfg_nxt[15:14];
      tach_openloop_select_r <= cfg_nxt[13:12];
      tach_divider_r <= cfg_nxt[11:8];
      cycle_adjust_select_r <= cfg_nxt[7];
      winding_res_shift_r <= cfg_nxt[6:4];
      winding_res_mantissa_r <= cfg_nxt[3:0];
    end
  end
endmodule // nvc_regs
`default_nettype wire

/* File: bench/nvc_regs_asserts.sv */
// port checker for the nvc register block
// assumes one clock and an async active high reset
`timescale 1ns/100ps
`default_nettype none
module nvc_regs_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_r,
  input wire logic drive_inhibit_r,
  input wire logic shadow_active_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence ctrl_wr_s;
    reg_wr && reg_addr == 8'h35;
  endsequence
  sequence rd_s(a);
    reg_rd && reg_addr == a;
  endsequence
  inhibit_write_a: assert property (reg_wr && reg_addr == 8'h60 |=>
    drive_inhibit_r == $past(reg_wdata[15])) else $error("inhibit bad");
  inhibit_hold_a: assert property (!(reg_wr && reg_addr == 8'h60) |=>
    $stable(drive_inhibit_r)) else $error("inhibit moved");
  inhibit_read_a: assert property (rd_s(8'h60) |=>
    reg_rdata_r == 16'h0000) else $error("inhibit readable");
  gap_low_a: assert property (reg_rd && reg_addr inside {[8'h37:8'h5f]}
    |=> reg_rdata_r == 16'h0000) else $error("gap1 not zero");
  gap_high_a: assert property (reg_rd && reg_addr inside {[8'h61:8'h8f]}
    |=> reg_rdata_r == 16'h0000) else $error("gap2 not zero");
  ctrl_bits_a: assert property (rd_s(8'h35) |=> (reg_rdata_r &
    16'heff8) == 16'h0000 && reg_rdata_r[1:0] != 2'b11)
    else $error("control spare bits");
  shadow_follow_a: assert property (ctrl_wr_s ##1 !(reg_wr &&
    reg_addr == 8'h35) |=> shadow_active_r == $past(reg_wdata[12], 2))
    else $error("shadow lag");
  rdata_hold_a: assert property (!reg_rd |=>
    $stable(reg_rdata_r)) else $error("read data moved");
  reset_zero_a: assert property ($fell(rst) |-> !drive_inhibit_r &&
    !shadow_active_r && reg_rdata_r == 16'h0000) else $error("reset value");
endmodule // nvc_regs_chk
bind nvc_regs nvc_regs_chk i_chk (.clk_sys(clk_sys), .rst(rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
  .drive_inhibit_r(drive_inhibit_r), .shadow_active_r(shadow_active_r));
`default_nettype wire

/* File: bench/nvc_host.sv */
// host side model: word reads, writes and single or bulk nv operations
// assumes strobes are taken on the rising edge
`timescale 1ns/100ps
`default_nettype none
`include "nvc_map.vh"
module nvc_host (
  input wire logic clk_sys,
  input wire logic [15:0] reg_rdata_r,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [15:0] reg_wdata = 16'h0000
);
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    // released lines flip so a stale value never looks valid
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata_r;
  endtask
  task automatic nv_op(input logic [7:0] loc, input logic [15:0] d,
    input logic [15:0] ctl, output logic ok);
    logic [15:0] s;
    ok = 1'b0;
    wr(8'h31, `NVC_KEY_VALUE);
    wr(8'h33, {8'h00, loc});
    wr(8'h34, d);
    wr(8'h60, 16'h8000);
    wr(8'h35, ctl);
    // ready drops on the same edge that takes the control write
    repeat (3) @(negedge clk_sys);
    // bulk walks every location, so allow far more polls than one access
    for (int i = 0; i < 100 && !ok; i++) begin
      rd(8'h32, s);
      ok = (s[0] === 1'b1);
    end
    wr(8'h60, 16'h0000);
  endtask
endmodule // nvc_host
`default_nettype wire

/* File: bench/tb_nvc_regs.sv */
// self-checking bench for nvc_regs
// assumes the host model in nvc_host.sv
`timescale 1ns/100ps
`default_nettype none
module tb_nvc_regs;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reg_wr, reg_rd, inh, shad;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, rdat;
  wire logic [15:0] cfg;
  int n_errors = 0;
  int comparisons = 0;
  always #50 clk_sys = ~clk_sys;
  nvc_regs #(.NV_DEPTH(8), .ACCESS_CYC(10)) i_dut (.clk_sys(clk_sys),
    .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_r(rdat), .drive_inhibit_r(inh),
    .shadow_active_r(shad), .dither_setting_r(cfg[15:14]),
    .tach_openloop_select_r(cfg[13:12]), .tach_divider_r(cfg[11:8]),
    .cycle_adjust_select_r(cfg[7]), .winding_res_shift_r(cfg[6:4]),
    .winding_res_mantissa_r(cfg[3:0]));
  nvc_host i_host (.clk_sys(clk_sys), .reg_rdata_r(rdat), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // resync reads back 0; code 11 is stored as off
  function logic [15:0] exp_ctrl(input logic [15:0] d);
    logic [15:0] m;
    m = d & 16'h1007;
    if (m[1:0] == 2'b11) m[1:0] = 2'b00;
    return m;
  endfunction
  task complete_run;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #2_000_000;
    n_errors++;
    complete_run();
  end
  initial begin
    logic [15:0] d, v, r;
    logic [7:0] a;
    logic ok;
    void'($urandom(32'h6dbf_0264));
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 8'h35 : (i == 1) ? 8'h36 : (i == 2) ? 8'h60 : 8'h90;
      i_host.rd(a, r);
      chk(r, 16'h0000);
    end
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      if (i < 4) d[1:0] = i[1:0];
      i_host.wr(8'h35, d);
      i_host.rd(8'h35, r);
      chk(r, exp_ctrl(d));
    end
    $display("test control done");
    i_host.wr(8'h60, 16'h8000);
    chk({15'h0, inh}, 16'h0001);
    i_host.rd(8'h60, r);
    chk(r, 16'h0000);
    i_host.wr(8'h60, 16'h0000);
    chk({15'h0, inh}, 16'h0000);
    $display("test inhibit done");
    for (int i = 0; i < 8; i++) begin
      a = (i % 2) ? 8'h61 + $urandom % 47 : 8'h37 + $urandom % 41;
      if (i < 4) a = (i == 0) ? 8'h37 : (i == 1) ? 8'h8f :
        (i == 2) ? 8'h5f : 8'h61;
      i_host.wr(a, $urandom);
      i_host.rd(a, r);
      chk(r, 16'h0000);
    end
    $display("test gaps done");
    v = $urandom;
    a = 8'h90 + $urandom % 7;
    i_host.nv_op(a, v, 16'h0005, ok);
    chk({15'h0, ok}, 16'h0001);
    i_host.nv_op(a, ~v, 16'h0001, ok);
    i_host.rd(8'h36, r);
    chk(r, v);
    $display("test single op done");
    i_host.nv_op(8'h90, v, 16'h0005, ok);
    d = ~v;
    i_host.wr(8'h90, d);
    i_host.rd(8'h90, r);
    chk(r, v);
    chk(cfg, v);
    chk({15'h0, shad}, 16'h0000);
    i_host.wr(8'h35, 16'h1000);
    i_host.wr(8'h90, d);
    i_host.rd(8'h90, r);
    chk(r, d);
    chk(cfg, d);
    chk({15'h0, shad}, 16'h0001);
    i_host.wr(8'h35, 16'h1100);
    i_host.rd(8'h90, r);
    chk(r, v);
    $display("test shadow done");
    d = v ^ 16'ha5a5;
    i_host.wr(8'h90, d);
    // bulk write copies the shadow word into every location
    i_host.nv_op(8'h90, d, 16'h1006, ok);
    chk({15'h0, ok}, 16'h0001);
    i_host.nv_op(8'h95, v, 16'h1001, ok);
    i_host.rd(8'h36, r);
    chk(r, d);
    $display("test bulk done");
    complete_run();
  end
endmodule // tb_nvc_regs
`default_nettype wire
